// ### hnc_ctrl.sv
// host controller that drives a byte-wide nand flash through its strobes and port
`timescale 1ns/100ps
`default_nettype none
module hnc_ctrl #(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      en,
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire hnc_pkg::hnc_op_t          cmd_op,
    input  wire logic [hnc_pkg::BLOCK_W-1:0] cmd_block,
    input  wire logic [hnc_pkg::PAGE_W-1:0]  cmd_page,
    input  wire logic [hnc_pkg::COL_W-1:0]   cmd_col,
    input  wire logic [hnc_pkg::COL_W-1:0]   cmd_len,
    output logic                           done,
    input  wire logic                      wr_valid,
    output logic                           wr_ready,
    input  wire logic [7:0]                wr_data,
    output logic                           rd_valid,
    output logic [7:0]                     rd_data,
    input  wire logic                      protect,
    output logic                           nand_ce_n,
    output logic                           nand_cle,
    output logic                           nand_ale,
    output logic                           nand_we_n,
    output logic                           output_strobe_n,
    output logic                           nand_wp_n,
    input  wire logic [7:0]                shared_byte_port_in,
    output logic [7:0]                     shared_byte_port_out,
    output logic                           shared_byte_port_oe,
    input  wire logic                      busy_indicator_n
);
    import hnc_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_WAIT, ST_BUSY, ST_DOUT, ST_DONE
    } hnc_state_t;

    hnc_state_t           state;
    hnc_op_t              op;
    logic [ROW_W-1:0]     row;
    logic [COL_W-1:0]     col;
    logic [COL_W-1:0]     len;
    logic [COL_W-1:0]     cnt;
    logic [2:0]           aidx;
    logic [2:0]           alast;
    logic [3:0]           ph;
    logic [7:0]           wcnt;
    logic                 fifo_valid;
    logic                 fifo_pop;
    logic [7:0]           fifo_data;
    logic                 fifo_in_ready;
    logic                 accept;
    logic                 wr_end;
    logic                 rd_end;
    logic [7:0]           abyte;

    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) begin : g_bad_fifo
        $error("fifo depth out of range");
    end

    // write buffer; program stalls when it runs dry
    hnc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .en        (en),
        .in_valid  (wr_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (wr_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );
    assign fifo_pop = en && state == ST_DIN && ph == 4'h0 && fifo_valid && cnt != len;

    // only status read and reset may go while the device is busy
    assign accept = cmd_valid && cmd_ready &&
                    (busy_indicator_n || cmd_op == OP_STATUS || cmd_op == OP_RESET);
    assign wr_end = ph == 4'(1 + WE_LOW_CYC + WE_HIGH_CYC);
    assign rd_end = ph == 4'(RE_LOW_CYC + RE_HIGH_CYC);

    // address byte order: column low, column high, row low, row mid, row bit 16
    always_comb begin
        case (aidx)
            3'h0:    abyte = col[7:0];
            3'h1:    abyte = {3'h0, col[12:8]};
            3'h2:    abyte = row[7:0];
            3'h3:    abyte = row[15:8];
            3'h4:    abyte = {7'h00, row[16]};
            default: abyte = 8'h00;
        endcase
    end

    function automatic logic [7:0] first_code(input hnc_op_t o);
        case (o)
            OP_READ:       first_code = CMD_READ_SETUP;
            OP_PROG:       first_code = CMD_DATA_IN;
            OP_ERASE:      first_code = CMD_ERASE_SETUP;
            OP_STATUS:     first_code = CMD_STATUS;
            OP_ID:         first_code = CMD_ID_READ;
            OP_CACHE:      first_code = CMD_READ_CACHE;
            OP_CACHE_LAST: first_code = CMD_READ_LAST;
            default:       first_code = CMD_RESET;
        endcase
    endfunction

    // sequencer; write cycles put latch levels at ph 0, strobe low at ph 1
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= ST_IDLE;
            op    <= OP_RESET;
            row   <= '0;
            col   <= '0;
            len   <= '0;
            cnt   <= '0;
            aidx  <= '0;
            alast <= '0;
            ph    <= '0;
            wcnt  <= '0;
        end else if (en) begin
            case (state)
                ST_IDLE: begin
                    ph <= '0;
                    if (accept) begin
                        op    <= cmd_op;
                        row   <= {cmd_block, cmd_page};
                        col   <= cmd_col;
                        len   <= cmd_len;
                        cnt   <= '0;
                        aidx  <= (cmd_op == OP_ERASE) ? 3'h2 : 3'h0;
                        alast <= (cmd_op == OP_ID) ? 3'h0 : 3'h4;
                        state <= ST_CMD1;
                    end
                end
                ST_CMD1: begin
                    ph <= wr_end ? 4'h0 : ph + 4'h1;
                    if (wr_end) begin
                        wcnt  <= (op == OP_STATUS) ? 8'(WHR_CYC) : 8'(WB_CYC);
                        state <= (op == OP_READ || op == OP_PROG || op == OP_ERASE ||
                                  op == OP_ID) ? ST_ADDR : ST_WAIT;
                    end
                end
                ST_ADDR: begin
                    ph <= wr_end ? 4'h0 : ph + 4'h1;
                    if (wr_end) begin
                        aidx <= aidx + 3'h1;
                        if (aidx == alast) begin
                            wcnt  <= 8'(WHR_CYC);
                            state <= (op == OP_PROG) ? ST_DIN : (op == OP_ID) ? ST_WAIT : ST_CMD2;
                        end
                    end
                end
                ST_DIN: begin
                    if (cnt == len) begin
                        state <= ST_CMD2;
                    end else if (ph != 4'h0 || fifo_valid) begin
                        ph <= wr_end ? 4'h0 : ph + 4'h1;
                        if (wr_end) begin
                            cnt <= cnt + 1'b1;
                        end
                    end
                end
                ST_CMD2: begin
                    ph <= wr_end ? 4'h0 : ph + 4'h1;
                    if (wr_end) begin
                        wcnt  <= 8'(WB_CYC);
                        state <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // busy is not looked at until the device has had time to drop it
                    wcnt <= wcnt - 8'h1;
                    if (wcnt == 8'h1) begin
                        cnt   <= '0;
                        state <= (op == OP_STATUS || op == OP_ID) ? ST_DOUT : ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (busy_indicator_n) begin
                        state <= (op == OP_PROG || op == OP_ERASE || op == OP_RESET) ?
                                 ST_DONE : ST_DOUT;
                    end
                end
                ST_DOUT: begin
                    ph <= rd_end ? 4'h0 : ph + 4'h1;
                    if (rd_end) begin
                        cnt <= cnt + 1'b1;
                        if (op == OP_STATUS || cnt + 1'b1 >= len) begin
                            state <= ST_DONE;
                        end
                    end
                end
                ST_DONE: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // strobes and port; latches drop at the end of each write cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            nand_ce_n            <= 1'b1;
            nand_cle             <= 1'b0;
            nand_ale             <= 1'b0;
            nand_we_n            <= 1'b1;
            output_strobe_n      <= 1'b1;
            shared_byte_port_out <= DQ_RESET;
            shared_byte_port_oe  <= 1'b0;
        end else if (en) begin
            nand_ce_n <= (state == ST_IDLE && !accept) || state == ST_DONE;
            if (state == ST_CMD1 || state == ST_ADDR || state == ST_CMD2 ||
                (state == ST_DIN && cnt != len && (ph != 4'h0 || fifo_valid))) begin
                if (ph == 4'h0) begin
                    nand_cle             <= state == ST_CMD1 || state == ST_CMD2;
                    nand_ale             <= state == ST_ADDR;
                    shared_byte_port_oe  <= 1'b1;
                    shared_byte_port_out <= state == ST_CMD1 ? first_code(op) :
                                            state == ST_ADDR ? abyte :
                                            state == ST_DIN  ? fifo_data :
                                            op == OP_READ    ? CMD_READ_GO :
                                            op == OP_ERASE   ? CMD_ERASE_GO :
                                            CMD_PROG_GO; // plain 10 confirm, never 15
                end
                nand_we_n <= !(ph >= 4'h1 && ph <= 4'(WE_LOW_CYC)); // low from ph 1 on
                if (wr_end) begin
                    nand_cle <= 1'b0;
                    nand_ale <= 1'b0;
                end
            end else if (state == ST_DOUT) begin
                shared_byte_port_oe <= 1'b0;
                output_strobe_n     <= ph >= 4'(RE_LOW_CYC); // high again at capture
            end else begin
                // busy wait and idle: both strobes parked high
                nand_we_n           <= 1'b1;
                output_strobe_n     <= 1'b1;
                shared_byte_port_oe <= 1'b0;
            end
        end
    end

    // user-side answers, all registered
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_ready <= 1'b0;
            done      <= 1'b0;
            rd_valid  <= 1'b0;
            rd_data   <= 8'h00;
            wr_ready  <= 1'b0;
            nand_wp_n <= 1'b0;
        end else if (en) begin
            cmd_ready <= state == ST_IDLE && !accept;
            done      <= state == ST_DONE;
            rd_valid  <= state == ST_DOUT && ph == 4'(RE_LOW_CYC);
            if (state == ST_DOUT && ph == 4'(RE_LOW_CYC)) begin
                rd_data <= shared_byte_port_in;
            end
            wr_ready  <= fifo_in_ready;
            nand_wp_n <= !protect;
        end
    end

    // checks on the pin protocol
    a_latch_exclusive: assert property (@(posedge clk) disable iff (!nrst)
        !(nand_cle && nand_ale) && !(!nand_we_n && !output_strobe_n))
        else $error("both latches or both strobes active");
    a_we_pulse_width: assert property (@(posedge clk) disable iff (!nrst || !en)
        $fell(nand_we_n) |-> !nand_we_n ##1 !nand_we_n ##1 nand_we_n)
        else $error("write strobe low time wrong");
    a_latch_drives_port: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nand_we_n) && (nand_cle || nand_ale) |-> shared_byte_port_oe && !nand_ce_n)
        else $error("latch cycle without port drive");
    a_addr_top_zero: assert property (@(posedge clk) disable iff (!nrst)
        $fell(nand_we_n) && nand_ale && aidx == 3'h4 |-> shared_byte_port_out[7:1] == 7'h00)
        else $error("fifth address byte carries nonzero upper bits");
    a_col_high_zero: assert property (@(posedge clk) disable iff (!nrst)
        $fell(nand_we_n) && nand_ale && aidx == 3'h1 |-> shared_byte_port_out[7:5] == 3'h0)
        else $error("column high byte carries nonzero upper bits");
    a_busy_quiet: assert property (@(posedge clk) disable iff (!nrst)
        state == ST_BUSY |-> ##1 (nand_we_n && output_strobe_n))
        else $error("strobe moved during busy wait");
    a_ready_before_cmd: assert property (@(posedge clk) disable iff (!nrst || !en)
        state == ST_IDLE && cmd_valid && !busy_indicator_n && cmd_op != OP_STATUS &&
        cmd_op != OP_RESET |=> state == ST_IDLE)
        else $error("command issued while device busy");
    a_no_cache_confirm: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nand_we_n) && nand_cle |-> shared_byte_port_out != CMD_PROG_CACHE)
        else $error("cached program confirm issued");
    a_read_strobe: assert property (@(posedge clk) disable iff (!nrst || !en)
        $fell(output_strobe_n) |-> !output_strobe_n [*3] ##1 (output_strobe_n && rd_valid))
        else $error("read strobe timing or capture wrong");

    c_read_done: cover property (@(posedge clk) disable iff (!nrst) op == OP_READ && done);
    c_prog_done: cover property (@(posedge clk) disable iff (!nrst) op == OP_PROG && done);
    c_erase_done: cover property (@(posedge clk) disable iff (!nrst) op == OP_ERASE && done);
    c_din_stall: cover property (@(posedge clk) disable iff (!nrst)
        state == ST_DIN && !fifo_valid && cnt != len);
endmodule : hnc_ctrl
`default_nettype wire

// ### hnc_ctrl_tb_top.sv
// self-checking bench for the host flash controller with queued read expectations
`timescale 1ns/100ps
`default_nettype none
module hnc_ctrl_tb_top;
    import hnc_pkg::*;
    logic clk = 0, nrst = 0, cmd_valid = 0, protect = 0, wr_valid = 0;
    hnc_op_t cmd_op = OP_STATUS;
    logic [BLOCK_W-1:0] blk = '0;
    logic [PAGE_W-1:0] pg = '0;
    logic [COL_W-1:0] col = '0, len = '0;
    logic [7:0] wr_data = 8'h00, rd_data, pout, dev_dq;
    logic cmd_ready, done, wr_ready, rd_valid, ce_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
    logic [31:0] rs = 32'had2f;
    logic [7:0] img [16];
    logic [7:0] expq [$];
    int n_mismatch = 0, check_count = 0, cyc = 0;
    wire [7:0] pin = oe ? pout : dev_dq;
    always #5 clk = ~clk;
    hnc_ctrl dut (.clk(clk), .nrst(nrst), .en(1'b1), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_op(cmd_op), .cmd_block(blk), .cmd_page(pg), .cmd_col(col), .cmd_len(len),
        .done(done), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_data(rd_data), .protect(protect), .nand_ce_n(ce_n),
        .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .output_strobe_n(re_n),
        .nand_wp_n(wp_n), .shared_byte_port_in(pin), .shared_byte_port_out(pout),
        .shared_byte_port_oe(oe), .busy_indicator_n(rb_n));
    hnc_nand_model dev (.clk(clk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .wp_n(wp_n), .din(pin), .dout(dev_dq), .rb_n(rb_n));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // issue one operation; valid drops once the controller has taken it
    task automatic op(input hnc_op_t o, input int n);
        int t;
        t = 0;
        @(negedge clk);
        cmd_op = o;
        len = n[COL_W-1:0];
        cmd_valid = 1;
        do @(posedge clk); while (!(cmd_ready && rb_n));
        @(negedge clk);
        cmd_valid = 0;
        while (done !== 1'b1 && t < 5000) begin
            @(posedge clk);
            t++;
        end
        chk({7'h0, done}, 8'h01);
        repeat (3) @(negedge clk);
    endtask : op
    // compare captured address bytes with the five-byte layout, last n of them
    task automatic chk_addr(input int n);
        logic [ROW_W-1:0] r;
        logic [7:0] ea [5];
        r = {blk, pg};
        ea = '{col[7:0], {3'b000, col[12:8]}, r[7:0], r[15:8], {7'h0, r[16]}};
        for (int i = 0; i < n; i++) chk(dev.adr[i], ea[i + 5 - n]);
    endtask : chk_addr
    // fill the buffer with 16 random bytes, then program them
    task automatic prog(input logic upd);
        for (int i = 0; i < 16; i++) begin
            rs = xs(rs);
            @(negedge clk);
            wr_valid = 1;
            wr_data = rs[7:0];
            do @(posedge clk); while (!wr_ready);
            if (upd) img[i] = rs[7:0];
        end
        @(negedge clk);
        wr_valid = 0;
        repeat (2) @(negedge clk);
        chk({7'h0, wr_ready}, 8'h00); // buffer full refuses more
        op(OP_PROG, 16);
    endtask : prog
    task automatic rd16(input hnc_op_t o);
        for (int i = 0; i < 16; i++) expq.push_back(img[i]);
        op(o, 16);
        chk(8'(expq.size()), 8'h00);
    endtask : rd16
    // results are popped oldest first as bytes come back
    always @(posedge clk) if (rd_valid === 1'b1) begin
        if (expq.size() > 0) chk(rd_data, expq.pop_front());
        else chk(8'h00, 8'h01);
    end
    // hang guard well above the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(negedge clk);
        nrst = 1;
        repeat (2) @(negedge clk);
        rs = xs(rs);
        blk = rs[10:0];
        pg = rs[16:11];
        col = {rs[28:20], 4'h0};
        prog(1'b1);
        chk_addr(5);
        chk(dev.cmd, CMD_PROG_GO);
        $display("test program done");
        rd16(OP_READ);
        chk_addr(5);
        chk(dev.cmd, CMD_READ_GO);
        $display("test read done");
        protect = 1;
        repeat (2) @(negedge clk);
        chk({7'h0, wp_n}, 8'h00);
        prog(1'b0);
        protect = 0;
        repeat (2) @(negedge clk);
        rd16(OP_READ); // old data survives
        $display("test protect done");
        rd16(OP_CACHE);
        rd16(OP_CACHE_LAST);
        $display("test cache read done");
        op(OP_ERASE, 0);
        chk_addr(3);
        chk(dev.cmd, CMD_ERASE_GO);
        op(OP_RESET, 0);
        chk(dev.cmd, CMD_RESET);
        $display("test erase reset done");
        expq.push_back(8'h40);
        op(OP_STATUS, 1);
        chk(dev.cmd, CMD_STATUS);
        chk(8'(expq.size()), 8'h00);
        $display("test status done");
        end_of_test();
    end
endmodule : hnc_ctrl_tb_top
`default_nettype wire

// ### hnc_fifo.sv
// parameterised first-in first-out buffer with registered full and empty
`timescale 1ns/100ps
`default_nettype none
module hnc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr;
    logic [AW-1:0]    rptr;
    logic [AW:0]      count;
    logic             full;
    logic             empty;
    logic             push;
    logic             pop;
    logic [AW:0]      next_count;

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least 2");
        end
    endgenerate

    // flags come from flops so the ready seen outside is clean
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem[rptr];
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // storage has no reset, only pointers, count and flags do
    always_ff @(posedge clk) begin
        if (en && push) begin
            mem[wptr] <= in_data;
        end
    end

    // pointers, count and flags
    always_ff @(posedge clk) begin
        if (!nrst) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
            full  <= 1'b0;
            empty <= 1'b1;
        end else if (en) begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            count <= next_count;
            full  <= (next_count == (AW + 1)'(DEPTH));
            empty <= (next_count == '0);
        end
    end
endmodule : hnc_fifo
`default_nettype wire

// ### hnc_nand_model.sv
// behavioural byte-wide flash device facing the host controller
`timescale 1ns/100ps
`default_nettype none
module hnc_nand_model (
    input  wire logic       clk,
    input  wire logic       ce_n,
    input  wire logic       cle,
    input  wire logic       ale,
    input  wire logic       we_n,
    input  wire logic       re_n,
    input  wire logic       wp_n,
    input  wire logic [7:0] din,
    output logic      [7:0] dout,
    output logic            rb_n
);
    logic [7:0] cmd = 8'h00; // power-on read setup
    logic [7:0] adr [5];
    logic [7:0] mem [16];
    logic [7:0] stage [16];
    logic [7:0] last = 8'h00;
    logic [12:0] col = 13'h0;
    int na = 0;
    int bsy = 0;
    initial rb_n = 1'b1;
    // latch on write strobe rise; only status and reset get through while busy
    always @(posedge we_n) if (!ce_n) begin
        if (cle && !ale && (rb_n || din == 8'h70 || din == 8'h71 || din == 8'hff)) begin
            cmd = din;
            na = 0;
            if (din == 8'h10 && wp_n) mem = stage; // program refused when protected
            if (din == 8'h30 || din == 8'hd0 || din == 8'hff || din == 8'h10 ||
                din == 8'h31 || din == 8'h3f || din == 8'h3a || din == 8'h15 || din == 8'h11)
                bsy = 20;
        end else if (ale && !cle && rb_n) begin
            if (na == 0) col = {5'h0, din};
            if (na < 5) adr[na] = din;
            na = na + 1;
        end else if (!cle && !ale && cmd == 8'h80 && rb_n) begin // data input
            stage[col[3:0]] = din;
            col = col + 13'h1;
        end
    end
    // busy count runs on the host clock; open-drain line pulled high when idle
    always @(posedge clk) begin
        if (bsy > 0) bsy = bsy - 1;
        rb_n <= (bsy == 0); // nonblocking so the host samples the old level
    end
    // next byte on strobe fall; a released port shows the inverse to expose stale sampling
    always @(negedge re_n) if (!ce_n) begin
        last = (cmd == 8'h70) ? {1'b0, rb_n, 6'h00} : mem[col[3:0]]; // bit 6 ready
        col = col + 13'h1;
    end
    always @* dout = (!ce_n && !re_n) ? last : ~last;
endmodule : hnc_nand_model
`default_nettype wire

// ### hnc_pkg.sv
// shared constants and types for the host-side nand flash controller
// Summary of operation
// - Host sends five address bytes: column low, column high, row low, mid, bit 16. Erase sends only the last three, ID only the first.
// - Strobe levels with chip select low pick command, address, data in or data out.
// - During read busy with chip select low, write and output strobes stay high.
// - Host ends cached multi-plane program with 81 then 10, else polls and resets. The controller issues neither 81 nor 11; program always ends with a plain 10.
package hnc_pkg;
    // command codes
    localparam logic [7:0] CMD_READ_SETUP   = 8'h00;
    localparam logic [7:0] CMD_READ_GO      = 8'h30;
    localparam logic [7:0] CMD_COL_CHANGE   = 8'h05;
    localparam logic [7:0] CMD_COL_GO       = 8'he0;
    localparam logic [7:0] CMD_READ_CACHE   = 8'h31;
    localparam logic [7:0] CMD_READ_LAST    = 8'h3f;
    localparam logic [7:0] CMD_DATA_IN      = 8'h80;
    localparam logic [7:0] CMD_PROG_GO      = 8'h10;
    localparam logic [7:0] CMD_IN_COL       = 8'h85;
    localparam logic [7:0] CMD_PROG_CACHE   = 8'h15;
    localparam logic [7:0] CMD_PLANE1_END   = 8'h11;
    localparam logic [7:0] CMD_PLANE2_IN    = 8'h81;
    localparam logic [7:0] CMD_COPY_READ    = 8'h3a;
    localparam logic [7:0] CMD_COPY_PROG    = 8'h8c;
    localparam logic [7:0] CMD_ERASE_SETUP  = 8'h60;
    localparam logic [7:0] CMD_ERASE_GO     = 8'hd0;
    localparam logic [7:0] CMD_ID_READ      = 8'h90;
    localparam logic [7:0] CMD_STATUS       = 8'h70;
    localparam logic [7:0] CMD_STATUS_MULTI = 8'h71;
    localparam logic [7:0] CMD_RESET        = 8'hff;

    // geometry
    localparam int COL_W       = 13;
    localparam int ROW_W       = 17;
    localparam int PAGE_W      = 6;
    localparam int BLOCK_W     = 11;
    localparam int PAGE_BYTES  = 4352;
    localparam int BLOCK_PAGES = 64;
    localparam int NUM_BLOCKS  = 2048;
    localparam int ADDR_BYTES  = 5;

    // timing, figures in ns and derived cycle counts at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_WP_NS       = 12;
    localparam int T_WC_NS       = 25;
    localparam int T_REA_NS      = 20;
    localparam int T_REH_NS      = 10;
    localparam int T_WB_NS       = 100;
    localparam int T_WHR_NS      = 60;
    localparam int WE_LOW_CYC    = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_HIGH_CYC   = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - WE_LOW_CYC;
    localparam int RE_LOW_CYC    = (T_REA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    localparam int RE_HIGH_CYC   = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC        = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHR_CYC       = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // values after reset
    localparam logic [7:0] DQ_RESET = 8'h00;

    typedef enum logic [2:0] {
        OP_READ,
        OP_PROG,
        OP_ERASE,
        OP_STATUS,
        OP_RESET,
        OP_ID,
        OP_CACHE,
        OP_CACHE_LAST
    } hnc_op_t;
endpackage : hnc_pkg
